// ===== shared/epir_defines.svh
// Register offsets, field positions and reset values of the pin request block
`ifndef EPIR_DEFINES_SVH
`define EPIR_DEFINES_SVH
`define EPIR_CTRL_STATUS_OFS 4'h0
`define EPIR_EVT_STATUS_OFS 4'h4
`define EPIR_EVT_MASK_OFS 4'h8
`define EPIR_BIT_MODE 0
`define EPIR_BIT_IE 1
`define EPIR_BIT_ACK 2
`define EPIR_BIT_FLAG 3
`define EPIR_BIT_PE 4
`define EPIR_BIT_POL 5
`define EPIR_BIT_PDD 6
`define EPIR_CTRL_RESET 8'h00
`define EPIR_EVT_W 2
`define EPIR_EVT_EDGE 0
`define EPIR_EVT_FLAG 1
`define EPIR_RESP_OKAY 2'h0
`define EPIR_RESP_SLVERR 2'h2
`endif

// ===== shared/epir_pkg.sv
// Types of the pin request block
package epir_pkg;
    typedef struct packed {
        logic pdd;
        logic pol;
        logic pe;
        logic ie;
        logic mode;
    } epir_ctrl_s;
    typedef enum logic [0:0] {
        EPIR_W_IDLE,
        EPIR_W_RESP
    } epir_wr_e;
    typedef struct packed {
        logic pull_enable;
        logic pull_up;
        logic pull_down;
    } epir_pull_s;
endpackage

// ===== hw/epir_pin_request.sv
// External pin interrupt request with AXI4-Lite registers
// What this block does
// RULE_01: Pin-enable bit 4 gates pin request detection
// RULE_02: Polarity bit 5: 0 falling/low, 1 rising/high
// RULE_03: Rising polarity swaps pull-up for pull-down
// RULE_04: Pull-disable bit 6 turns pull off when enabled
// RULE_05: Read-only request flag at bit 3
// RULE_06: Acknowledge bit 2 clears flag, reads zero
// RULE_07: Level mode: acknowledge fails while pin asserted
// RULE_08: Interrupt-enable bit 1 drives processor request
// RULE_09: Mode bit 0: edge-only or edge-and-level
// RULE_10: Edge is deasserted-to-asserted; level holds flag
// RULE_11: Enabling pin sets flag; software acknowledges first
// RULE_12: Synchronous monitor; asynchronous wake in stop
// RULE_13: Two-stage synchroniser before detection
// RULE_14: Edge with acknowledge keeps flag set
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "epir_defines.svh"
module epir_pin_request
    import epir_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request pin and pull control
    input wire logic req_pin,
    output epir_pull_s pull,
    // Stop-mode wake and processor requests
    input wire logic clocks_stopped,
    output logic wake_req,
    output logic cpu_irq,
    output logic irq
);
    // Register state
    epir_ctrl_s ctrl_r, ctrl_nxt;
    logic flag_r, flag_nxt;
    logic [`EPIR_EVT_W-1:0] evt_r, evt_nxt, mask_r, mask_nxt;
    logic sync1_r, sync2_r, prev_r, sync_nxt, prev_nxt;
    epir_wr_e wst_r, wst_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [3:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic pull_en_r, pull_up_r, pull_dn_r;
    logic pull_en_nxt, pull_up_nxt, pull_dn_nxt;
    logic cpu_irq_r, cpu_irq_nxt, irq_r, irq_nxt;

    function automatic logic addr_hit(input logic [3:0] a);
        addr_hit = (a == `EPIR_CTRL_STATUS_OFS) || (a == `EPIR_EVT_STATUS_OFS) ||
                   (a == `EPIR_EVT_MASK_OFS);
    endfunction

    // Pin level as asserted in the chosen polarity
    function automatic logic asserted(input logic lvl, input logic pol);
        asserted = pol ? lvl : ~lvl; // see RULE_02
    endfunction

    logic do_write, ack_wr, pin_asserted, edge_evt, level_hold, pe_rise;
    logic [7:0] ctrl_rd;

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`EPIR_BIT_MODE] = ctrl_r.mode;
        ctrl_rd[`EPIR_BIT_IE] = ctrl_r.ie;
        ctrl_rd[`EPIR_BIT_ACK] = 1'b0; // see RULE_06
        ctrl_rd[`EPIR_BIT_FLAG] = flag_r; // see RULE_05
        ctrl_rd[`EPIR_BIT_PE] = ctrl_r.pe;
        ctrl_rd[`EPIR_BIT_POL] = ctrl_r.pol;
        ctrl_rd[`EPIR_BIT_PDD] = ctrl_r.pdd;
    end

    // Synchroniser and edge detection
    always_comb begin
        sync_nxt = sync1_r; // see RULE_13
        prev_nxt = sync2_r;
        pin_asserted = ctrl_r.pe && asserted(sync2_r, ctrl_r.pol); // see RULE_01
        // Old level is judged under the current polarity, so a polarity flip alone
        // never looks like an edge; software should acknowledge after reconfiguring
        edge_evt = pin_asserted && !asserted(prev_r, ctrl_r.pol); // see RULE_10
        level_hold = ctrl_r.mode && pin_asserted; // see RULE_09
    end

    // Bus write side
    always_comb begin
        wst_nxt = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb0_nxt = wstrb0_r;
        bresp_nxt = bresp_r;
        do_write = 1'b0;
        s_axi_awready = (wst_r == EPIR_W_IDLE) && !aw_got_r;
        s_axi_wready = (wst_r == EPIR_W_IDLE) && !w_got_r;
        case (wst_r)
            EPIR_W_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb0_nxt = s_axi_wstrb[0];
                end
                if (aw_got_r && w_got_r) begin
                    do_write = wstrb0_r && addr_hit(awaddr_r);
                    bresp_nxt = addr_hit(awaddr_r) ? `EPIR_RESP_OKAY : `EPIR_RESP_SLVERR;
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                    wst_nxt = EPIR_W_RESP;
                end
            end
            EPIR_W_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = EPIR_W_IDLE;
                end
            end
            default: begin
                wst_nxt = EPIR_W_IDLE;
            end
        endcase
    end

    // Register updates, flag and events
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        evt_nxt = evt_r;
        ack_wr = 1'b0;
        pe_rise = 1'b0;
        if (do_write && awaddr_r == `EPIR_CTRL_STATUS_OFS) begin
            ctrl_nxt.mode = wdata_r[`EPIR_BIT_MODE];
            ctrl_nxt.ie = wdata_r[`EPIR_BIT_IE];
            ctrl_nxt.pe = wdata_r[`EPIR_BIT_PE];
            ctrl_nxt.pol = wdata_r[`EPIR_BIT_POL];
            ctrl_nxt.pdd = wdata_r[`EPIR_BIT_PDD];
            ack_wr = wdata_r[`EPIR_BIT_ACK]; // see RULE_06
            pe_rise = wdata_r[`EPIR_BIT_PE] && !ctrl_r.pe;
        end
        if (do_write && awaddr_r == `EPIR_EVT_MASK_OFS) begin
            mask_nxt = wdata_r[`EPIR_EVT_W-1:0];
        end
        if (do_write && awaddr_r == `EPIR_EVT_STATUS_OFS) begin
            evt_nxt = evt_r & ~wdata_r[`EPIR_EVT_W-1:0];
        end
        // A write that enables the pin sets the flag; it must be acknowledged
        // before interrupts are enabled
        flag_nxt = flag_r;
        if (ack_wr) begin
            flag_nxt = 1'b0; // see RULE_06
        end
        if (edge_evt || level_hold || pe_rise) begin
            flag_nxt = 1'b1; // see RULE_07 see RULE_11 see RULE_14
        end
        if (!ctrl_nxt.pe && !ctrl_r.pe) begin
            flag_nxt = flag_nxt && !ack_wr;
        end
        // Hardware sets win over the write-one clear
        if (edge_evt) begin
            evt_nxt[`EPIR_EVT_EDGE] = 1'b1;
        end
        if (flag_nxt && !flag_r) begin
            evt_nxt[`EPIR_EVT_FLAG] = 1'b1;
        end
        cpu_irq_nxt = ctrl_nxt.ie && flag_nxt; // see RULE_08
        irq_nxt = |(evt_nxt & mask_nxt);
        // Pull device follows pin enable, polarity and disable
        pull_en_nxt = ctrl_nxt.pe && !ctrl_nxt.pdd; // see RULE_04
        pull_up_nxt = pull_en_nxt && !ctrl_nxt.pol; // see RULE_03
        pull_dn_nxt = pull_en_nxt && ctrl_nxt.pol; // see RULE_03
    end

    // Bus read side
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        s_axi_arready = !rvalid_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = addr_hit(s_axi_araddr) ? `EPIR_RESP_OKAY : `EPIR_RESP_SLVERR;
            case (s_axi_araddr)
                `EPIR_CTRL_STATUS_OFS: rdata_nxt = {24'h000000, ctrl_rd};
                `EPIR_EVT_STATUS_OFS: rdata_nxt = {30'h0, evt_r};
                `EPIR_EVT_MASK_OFS: rdata_nxt = {30'h0, mask_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= '0;
            flag_r <= 1'b0;
            evt_r <= '0;
            mask_r <= '0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            wst_r <= EPIR_W_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h00000000;
            wstrb0_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= 2'h0;
            pull_en_r <= 1'b0;
            pull_up_r <= 1'b0;
            pull_dn_r <= 1'b0;
            cpu_irq_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
            sync1_r <= req_pin; // see RULE_13
            sync2_r <= sync_nxt;
            prev_r <= prev_nxt;
            wst_r <= wst_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb0_r <= wstrb0_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            pull_en_r <= pull_en_nxt;
            pull_up_r <= pull_up_nxt;
            pull_dn_r <= pull_dn_nxt;
            cpu_irq_r <= cpu_irq_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Wake path is pure gating so it works with the clock stopped
    assign wake_req = clocks_stopped && ctrl_r.pe && asserted(req_pin, ctrl_r.pol); // see RULE_12
    assign s_axi_bvalid = (wst_r == EPIR_W_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign pull = '{pull_enable: pull_en_r, pull_up: pull_up_r, pull_down: pull_dn_r};
    assign cpu_irq = cpu_irq_r;
    assign irq = irq_r;
endmodule

// ===== bench/epir_pin_src.sv
// Model of the external source on the request pin
`timescale 1ns/100ps
module epir_pin_src
    import epir_pkg::*;
(
    // Clock and bench control
    input wire logic aclk,
    input wire logic drv_en,
    input wire logic drv_val,
    // Pull state and pin
    input epir_pull_s pull,
    output logic req_pin
);
    logic last_r = 1'b1;
    always_ff @(posedge aclk) begin
        last_r <= req_pin;
    end
    // A released pin with no pull floats, so it never keeps its last value
    always_comb begin
        if (drv_en) begin
            req_pin = drv_val;
        end else if (pull.pull_enable) begin
            req_pin = pull.pull_up;
        end else begin
            req_pin = ~last_r;
        end
    end
endmodule

// ===== bench/epir_pin_request_asserts.sv
// Checker for the pin request block ports
`timescale 1ns/100ps
module epir_pin_request_asserts
    import epir_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Pin side
    input epir_pull_s pull,
    input wire logic clocks_stopped,
    input wire logic wake_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] ra_r;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ra_r <= s_axi_araddr;
        end
    end
    pull_excl_a: assert property (!(pull.pull_up && pull.pull_down))
        else $error("pull up and down together");
    pull_dir_a: assert property (pull.pull_enable |-> pull.pull_up ^ pull.pull_down)
        else $error("pull enabled without direction");
    wake_gate_a: assert property (wake_req |-> clocks_stopped)
        else $error("wake request while clocks run");
    ack_zero_a: assert property (s_axi_rvalid && ra_r == 4'h0 |-> s_axi_rdata[2] == 1'b0)
        else $error("acknowledge bit reads one");
    ctrl_width_a: assert property (s_axi_rvalid && ra_r == 4'h0 |-> s_axi_rdata[31:7] == 25'h0)
        else $error("control read has high bits");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer waits");
    rresp_ok_a: assert property (s_axi_rvalid && (ra_r == 4'h0 || ra_r == 4'h4 ||
        ra_r == 4'h8) |-> s_axi_rresp == 2'h0)
        else $error("mapped read answered with error");
endmodule
bind epir_pin_request epir_pin_request_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .pull(pull), .clocks_stopped(clocks_stopped), .wake_req(wake_req));

// ===== bench/epir_pin_request_bench.sv
// Bench for the pin request block
`timescale 1ns/100ps
module epir_pin_request_bench;
    import epir_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic stopped = 0, den = 1, dval = 1, awr, wr_rdy, bv, arr, rv, pin, wake, cpu_irq, irq;
    logic [3:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata, rdat;
    logic [1:0] bresp, rresp, rsp, wsp;
    epir_pull_s pull;
    int miscompares = 0, n_compared = 0;
    epir_pin_request dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .req_pin(pin), .pull(pull), .clocks_stopped(stopped), .wake_req(wake),
        .cpu_irq(cpu_irq), .irq(irq));
    epir_pin_src src (.aclk(aclk), .drv_en(den), .drv_val(dval), .pull(pull), .req_pin(pin));
    initial begin
        forever #4 aclk = ~aclk;
    end
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Handshakes are judged at the falling edge, where ready is already settled
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ao = 0, wo = 0, dn = 0;
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        for (int n = 0; !dn; n++) begin
            if (n == 40) begin miscompares++; give_verdict; end
            @(negedge aclk);
            ao |= awv & awr; wo |= wv & wr_rdy; dn = bv & br; wsp = bresp;
            @(posedge aclk);
            if (ao) awv <= 0;
            if (wo) wv <= 0;
            if (dn) br <= 0;
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic ao = 0, dn = 0;
        @(posedge aclk);
        ara <= a; arv <= 1; rr <= 1;
        for (int n = 0; !dn; n++) begin
            if (n == 40) begin miscompares++; give_verdict; end
            @(negedge aclk);
            ao |= arv & arr; dn = rv & rr; rdat = rdata; rsp = rresp;
            @(posedge aclk);
            if (ao) arv <= 0;
            if (dn) rr <= 0;
        end
        chk(rdat, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic drive(input logic e, input logic v);
        @(posedge aclk);
        den <= e; dval <= v;
    endtask
    task automatic t_reset;
        rdc(4'h0, 32'h0);
        rdc(4'hc, 32'h0);
        chk(rsp, 2'h2);
        wr(4'hc, 32'hff);
        chk(wsp, 2'h2);
        $display("t_reset done");
    endtask
    task automatic t_enable;
        wr(4'h0, 32'h10);
        rdc(4'h0, 32'h18);
        cyc(1);
        chk(pull, 3'h6);
        wr(4'h0, 32'h14);
        rdc(4'h0, 32'h10);
        $display("t_enable done");
    endtask
    task automatic t_edge;
        // The acknowledge commits on the edge where the synchronised fall sets the flag
        drive(1, 0);
        wr(4'h0, 32'h14);
        cyc(5);
        rdc(4'h0, 32'h18);
        wr(4'h0, 32'h12);
        cyc(2);
        chk(cpu_irq, 1'b1);
        wr(4'h0, 32'h16);
        cyc(2);
        chk(cpu_irq, 1'b0);
        rdc(4'h0, 32'h12);
        drive(1, 1);
        $display("t_edge done");
    endtask
    task automatic t_level;
        wr(4'h0, 32'h11);
        drive(1, 0);
        cyc(5);
        wr(4'h0, 32'h15);
        rdc(4'h0, 32'h19);
        drive(1, 1);
        cyc(5);
        wr(4'h0, 32'h15);
        rdc(4'h0, 32'h11);
        $display("t_level done");
    endtask
    task automatic t_rise;
        wr(4'h0, 32'h34);
        cyc(1);
        chk(pull, 3'h5);
        drive(0, 0);
        cyc(5);
        wr(4'h0, 32'h34);
        drive(1, 1);
        cyc(5);
        rdc(4'h0, 32'h38);
        wr(4'h0, 32'h74);
        cyc(1);
        chk(pull.pull_enable, 1'b0);
        $display("t_rise done");
    endtask
    task automatic t_events;
        rdc(4'h4, 32'h3);
        wr(4'h8, 32'h1);
        cyc(2);
        chk(irq, 1'b1);
        wr(4'h8, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        wr(4'h4, 32'h3);
        rdc(4'h4, 32'h0);
        $display("t_events done");
    endtask
    // Answers left waiting for several cycles must stand until they are taken
    task automatic t_stall;
        logic ao = 0, wo = 0, dn = 0;
        @(posedge aclk);
        awa <= 4'h8; wd <= 32'h2; awv <= 1; wv <= 1; br <= 0; ara <= 4'h8;
        for (int n = 0; !(ao && wo && dn); n++) begin
            if (n == 40) begin miscompares++; give_verdict; end
            @(negedge aclk);
            ao |= awv & awr; wo |= wv & wr_rdy; dn = bv;
            @(posedge aclk);
            if (ao) awv <= 0;
            if (wo) wv <= 0;
        end
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(bv, 1'b1);
        @(posedge aclk);
        br <= 1;
        @(negedge aclk);
        chk(bv & br, 1'b1);
        @(posedge aclk);
        br <= 0;
        arv <= 1;
        dn = 0;
        for (int n = 0; !dn; n++) begin
            if (n == 40) begin miscompares++; give_verdict; end
            @(negedge aclk);
            dn = arv & arr;
            @(posedge aclk);
            if (dn) arv <= 0;
        end
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(rv, 1'b1);
        chk(rdata, 32'h2);
        @(posedge aclk);
        rr <= 1;
        @(negedge aclk);
        chk(rv & rr, 1'b1);
        @(posedge aclk);
        rr <= 0;
        wr(4'h8, 32'h0);
        $display("t_stall done");
    endtask
    task automatic t_wake;
        wr(4'h0, 32'h0);
        drive(1, 0);
        cyc(5);
        rdc(4'h0, 32'h0);
        @(posedge aclk) stopped <= 1;
        cyc(1);
        chk(wake, 1'b0);
        wr(4'h0, 32'h10);
        cyc(1);
        chk(wake, 1'b1);
        @(posedge aclk) stopped <= 0;
        $display("t_wake done");
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_enable;
        t_edge;
        t_level;
        t_rise;
        t_events;
        t_stall;
        t_wake;
        give_verdict;
    end
endmodule
